// *** verif/cfrc_host.sv ***
`timescale 1ns/1ps
module cfrc_host (
  input  wire       CLK,
  input  wire [7:0] CMD_RDATA,
  input  wire       CMD_RVALID,
  output reg        CMD_WRITE = 0,
  output reg        CMD_READ  = 0,
  output reg  [7:0] CMD_CODE  = 8'h00,
  output reg  [7:0] CMD_WDATA = 8'h00
);
  // released lines show the inverse so a stale value cannot pass
  task wr(input [7:0] c, input [7:0] d); begin
    @(posedge CLK); #1 CMD_WRITE = 1; CMD_CODE = c; CMD_WDATA = d;
    @(posedge CLK); #1 CMD_WRITE = 0; CMD_CODE = ~c; CMD_WDATA = ~d;
  end endtask
  task rd(input [7:0] c, output [8:0] d); begin
    @(posedge CLK); #1 CMD_READ = 1; CMD_CODE = c;
    @(posedge CLK); #1 CMD_READ = 0; CMD_CODE = ~c; d = {CMD_RVALID, CMD_RDATA};
  end endtask
endmodule // cfrc_host

// *** verif/cfrc_sva.sv ***
`timescale 1ns/1ps
module cfrc_sva (
  input wire CLK, RST_N, CLEAR_FAULTS, OC_FAULT, UC_FAULT, CMD_READ, CMD_RVALID,
  input wire OUTPUT_ON_CMD, OTHER_SHUTDOWN, OC_STATUS, UC_STATUS,
  input wire ALERT_LINE_N, OUTPUT_ENABLE, RESTART_PULSE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  oc_set_cause_a: assert property ($rose(OC_STATUS) |-> $past(OC_FAULT))
    else $error("oc status without fault");
  uc_set_cause_a: assert property ($rose(UC_STATUS) |-> $past(UC_FAULT))
    else $error("uc status without fault");
  alert_low_a: assert property (OC_STATUS || UC_STATUS |-> !ALERT_LINE_N)
    else $error("alert high with status set");
  status_sticky_a: assert property (OC_STATUS && !CLEAR_FAULTS |=> OC_STATUS)
    else $error("status lost without clear");
  off_at_once_a: assert property ($rose(OC_STATUS) |-> !OUTPUT_ENABLE)
    else $error("output on at fault");
  pulse_after_on_a: assert property ($rose(RESTART_PULSE) |-> $past(OUTPUT_ENABLE))
    else $error("pulse without attempt");
  retry_stops_a: assert property ((!OUTPUT_ON_CMD || OTHER_SHUTDOWN) [*3]
    |-> !$rose(RESTART_PULSE)) else $error("retry while stopped");
  read_answer_a: assert property (CMD_READ |=> CMD_RVALID)
    else $error("no read answer");
  cover property ($rose(RESTART_PULSE));
  cover property ($fell(OC_STATUS));
  cover property ($rose(UC_STATUS));
endmodule // cfrc_sva

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  reg        clk = 0, rst_n = 0, clr = 0, oc = 0, uc = 0, on = 1, oth = 0;
  wire       wr, rd, rv, oc_st, uc_st, alert_n, oe, rp;
  wire [7:0] code, wd, rdat;
  reg  [8:0] r;
  integer    num_errors = 0, checks_done = 0, n, k;
  cfrc_current_fault_retry #(.UNIT_CYCLES(4), .PULSE_CYCLES(2)) i_cfrc_current_fault_retry (
    .CLK(clk), .RST_N(rst_n), .CONFIG_STRAP_ZERO(8'h8a), .CMD_WRITE(wr), .CMD_READ(rd),
    .CMD_CODE(code), .CMD_WDATA(wd), .CLEAR_FAULTS(clr), .OC_FAULT(oc), .UC_FAULT(uc),
    .OUTPUT_ON_CMD(on), .OTHER_SHUTDOWN(oth), .CMD_RDATA(rdat), .CMD_RVALID(rv),
    .OC_STATUS(oc_st), .UC_STATUS(uc_st), .ALERT_LINE_N(alert_n), .OUTPUT_ENABLE(oe),
    .RESTART_PULSE(rp));
  cfrc_host i_cfrc_host (.CLK(clk), .CMD_RDATA(rdat), .CMD_RVALID(rv), .CMD_WRITE(wr),
    .CMD_READ(rd), .CMD_CODE(code), .CMD_WDATA(wd));
  initial forever #10 clk = ~clk;
  task chk(input [8:0] seen, input [8:0] exp); begin
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  end endtask
  task wrap_up; begin
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  end endtask
  task cyc(input integer m); begin repeat (m) @(posedge clk); #1; end endtask
  task wait_oe; begin n = 0; while (oe !== 1'b1 && n < 100) begin cyc(1); n = n + 1; end end endtask
  initial begin
    cyc(12); rst_n = 1; cyc(2);
    i_cfrc_host.rd(8'he5, r); chk(r, 9'h18a);
    i_cfrc_host.rd(8'he6, r); chk(r, 9'h18a);
    i_cfrc_host.wr(8'he5, 8'h80); i_cfrc_host.wr(8'he6, 8'h4f); i_cfrc_host.wr(8'h00, 8'hff);
    i_cfrc_host.rd(8'he5, r); chk(r, 9'h180);
    i_cfrc_host.rd(8'he6, r); chk(r, 9'h14f);
    i_cfrc_host.rd(8'h00, r); chk(r, 9'h100);
    uc = 1; cyc(3); chk({uc_st, alert_n, oe}, 3'b011);
    uc = 0; oc = 1; cyc(1); oc = 0; cyc(1);
    chk({oc_st, alert_n, oe}, 3'b100);
    cyc(40); chk({oc_st, oe}, 2'b10);
    clr = 1; cyc(1); clr = 0; cyc(1); chk({oc_st, alert_n}, 2'b01);
    i_cfrc_host.wr(8'he6, 8'h9a);
    // delay field 2 with a 4-cycle unit: 12 cycles between starts
    for (k = 0; k < 2; k = k + 1) begin
      uc = 1; cyc(1); wait_oe; chk(n > 9 && n < 14, 1);
      cyc(1); wait_oe; chk(n > 9 && n < 14, 1);
      cyc(1); chk(rp, 1);
      chk(uc_st, 1);
      on = (k == 1); oth = (k == 1); cyc(40); chk(oe, 0);
      uc = 0; on = 1; oth = 0; clr = 1; cyc(1); clr = 0; cyc(2);
    end
    wrap_up;
  end
  initial begin #200000; num_errors = num_errors + 1; wrap_up; end
endmodule // tb
bind cfrc_current_fault_retry cfrc_sva i_cfrc_sva (.*);

// *** verilog/cfrc_current_fault_retry.v ***
`timescale 1ns/1ps
`include "cfrc_defines.vh"
module cfrc_current_fault_retry #(
  parameter UNIT_CYCLES = `CFRC_UNIT_CYCLES,
  parameter PULSE_CYCLES = `CFRC_RETRY_PULSE
) (
  input  wire       CLK,
  input  wire       RST_N,
  input  wire [7:0] CONFIG_STRAP_ZERO,
  input  wire       CMD_WRITE,
  input  wire       CMD_READ,
  input  wire [7:0] CMD_CODE,
  input  wire [7:0] CMD_WDATA,
  input  wire       CLEAR_FAULTS,
  input  wire       OC_FAULT,
  input  wire       UC_FAULT,
  input  wire       OUTPUT_ON_CMD,
  input  wire       OTHER_SHUTDOWN,
  output reg  [7:0] CMD_RDATA,
  output reg        CMD_RVALID,
  output reg        OC_STATUS,
  output reg        UC_STATUS,
  output reg        ALERT_LINE_N,
  output reg        OUTPUT_ENABLE,
  output reg        RESTART_PULSE
);
  localparam ST_RUN   = 3'b001;
  localparam ST_OFF   = 3'b010;
  localparam ST_RETRY = 3'b100;
  localparam CHANNELS = 2;

  // sized copies so counter loads and compares keep the counters' widths
  localparam [31:0] UNIT_LAST  = UNIT_CYCLES - 1;
  localparam [31:0] PULSE_LOAD = PULSE_CYCLES;

  reg  [7:0]  oc_action_reg;
  reg  [7:0]  oc_action_next;
  reg  [7:0]  uc_action_reg;
  reg  [7:0]  uc_action_next;
  reg         strap_load_reg;
  reg  [7:0]  rdata_next;
  reg         oc_status_next;
  reg         uc_status_next;
  reg         alert_next;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [2:0]  delay_reg;
  reg  [2:0]  delay_next;
  reg  [2:0]  units_reg;
  reg  [2:0]  units_next;
  reg  [31:0] presc_reg;
  reg  [31:0] presc_next;
  reg  [7:0]  pulse_reg;
  reg  [7:0]  pulse_next;
  reg         enable_next;
  wire [15:0] actions;
  wire [1:0]  fault_in;
  wire [1:0]  fault_hit;
  wire        oc_hit;
  wire        uc_hit;
  wire        any_hit;
  wire [7:0]  act;
  wire        unit_done;
  wire        attempt_due;

  // channel 0 is overcurrent, channel 1 undercurrent
  assign actions  = {uc_action_reg, oc_action_reg};
  assign fault_in = {UC_FAULT, OC_FAULT};

  // outside retry, a fault only responds while the code is the one defined disable code;
  // the unused codes leave the fault unanswered: no status, no alert
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_hit
      assign fault_hit[ch] = fault_in[ch] &&
        (actions[8*ch+`CFRC_RESP_MSB:8*ch+`CFRC_RESP_LSB] == `CFRC_RESP_DISABLE);
    end
  endgenerate

  assign oc_hit  = fault_hit[0];
  assign uc_hit  = fault_hit[1];
  assign any_hit = oc_hit | uc_hit;

  // overcurrent takes priority when both trip together
  assign act = oc_hit ? oc_action_reg : uc_action_reg;

  assign unit_done   = (presc_reg == UNIT_LAST);
  assign attempt_due = unit_done && (units_reg == delay_reg);

  // action registers: strap first, then host writes
  always @* begin
    oc_action_next = oc_action_reg;
    uc_action_next = uc_action_reg;
    if (strap_load_reg) begin
      oc_action_next = CONFIG_STRAP_ZERO;
      uc_action_next = CONFIG_STRAP_ZERO;
    end else if (CMD_WRITE && CMD_CODE == `CFRC_CMD_OC_ACTION) begin
      oc_action_next = CMD_WDATA;
    end else if (CMD_WRITE && CMD_CODE == `CFRC_CMD_UC_ACTION) begin
      uc_action_next = CMD_WDATA;
    end
  end

  // read data is zero for any code this block does not own
  always @* begin
    if (CMD_READ && CMD_CODE == `CFRC_CMD_OC_ACTION) begin
      rdata_next = oc_action_reg;
    end else if (CMD_READ && CMD_CODE == `CFRC_CMD_UC_ACTION) begin
      rdata_next = uc_action_reg;
    end else begin
      rdata_next = 8'h00;
    end
  end

  // strap is caught on the first clock after release, never under reset
  always @(posedge CLK) begin
    if (!RST_N) begin
      strap_load_reg <= 1'b1;
      oc_action_reg  <= 8'h00;
      uc_action_reg  <= 8'h00;
      CMD_RDATA      <= 8'h00;
      CMD_RVALID     <= 1'b0;
    end else begin
      strap_load_reg <= 1'b0;
      oc_action_reg  <= oc_action_next;
      uc_action_reg  <= uc_action_next;
      CMD_RDATA      <= rdata_next;
      CMD_RVALID     <= CMD_READ;
    end
  end

  // status: set wins over clear in the same cycle, so no fault is lost
  always @* begin
    oc_status_next = oc_hit | (OC_STATUS & ~CLEAR_FAULTS);
    uc_status_next = uc_hit | (UC_STATUS & ~CLEAR_FAULTS);
    alert_next     = ~(any_hit | ((OC_STATUS | UC_STATUS) & ~CLEAR_FAULTS));
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      OC_STATUS    <= 1'b0;
      UC_STATUS    <= 1'b0;
      ALERT_LINE_N <= 1'b1;
    end else begin
      OC_STATUS    <= oc_status_next;
      UC_STATUS    <= uc_status_next;
      ALERT_LINE_N <= alert_next;
    end
  end

  // retry sequencer; the prescaler runs free and is restarted on each
  // fault hit in run and on each attempt, which costs a 32-bit counter but no divider
  always @* begin
    state_next  = state_reg;
    enable_next = OUTPUT_ENABLE;
    delay_next  = delay_reg;
    units_next  = unit_done ? units_reg + 3'h1 : units_reg;
    presc_next  = unit_done ? 32'h0 : presc_reg + 32'h1;
    pulse_next  = (pulse_reg != 8'h00) ? pulse_reg - 8'h01 : pulse_reg;
    case (state_reg)
      ST_RUN: begin
        enable_next = OUTPUT_ON_CMD & ~OTHER_SHUTDOWN;
        if (any_hit) begin
          enable_next = 1'b0;
          presc_next  = 32'h0;
          units_next  = 3'h0;
          delay_next  = act[`CFRC_DELAY_MSB:`CFRC_DELAY_LSB];
          if (act[`CFRC_RETRY_MSB:`CFRC_RETRY_LSB] == `CFRC_RETRY_NONE) begin
            state_next = ST_OFF;
          end else begin
            state_next = ST_RETRY;
          end
        end
      end
      ST_OFF: begin
        enable_next = 1'b0;
        if (CLEAR_FAULTS) begin
          state_next = ST_RUN;
        end
      end
      ST_RETRY: begin
        if (!OUTPUT_ON_CMD || OTHER_SHUTDOWN) begin
          enable_next = 1'b0;
          state_next  = ST_OFF;
        end else if (attempt_due) begin
          // restart without looking at the fault inputs; a persisting
          // fault simply restarts the interval from this attempt
          enable_next = 1'b1;
          pulse_next  = PULSE_LOAD[7:0];
          units_next  = 3'h0;
          presc_next  = 32'h0;
        end else if (OC_FAULT || UC_FAULT) begin
          enable_next = 1'b0;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      state_reg     <= ST_RUN;
      OUTPUT_ENABLE <= 1'b0;
      RESTART_PULSE <= 1'b0;
      delay_reg     <= 3'h0;
      units_reg     <= 3'h0;
      presc_reg     <= 32'h0;
      pulse_reg     <= 8'h00;
    end else begin
      state_reg     <= state_next;
      OUTPUT_ENABLE <= enable_next;
      RESTART_PULSE <= (pulse_reg != 8'h00);
      delay_reg     <= delay_next;
      units_reg     <= units_next;
      presc_reg     <= presc_next;
      pulse_reg     <= pulse_next;
    end
  end
endmodule // cfrc_current_fault_retry

// *** verilog/cfrc_defines.vh ***
`ifndef CFRC_DEFINES_VH
`define CFRC_DEFINES_VH
`define CFRC_CMD_OC_ACTION     8'he5
`define CFRC_CMD_UC_ACTION     8'he6
`define CFRC_RESP_MSB          7
`define CFRC_RESP_LSB          6
`define CFRC_RETRY_MSB         5
`define CFRC_RETRY_LSB         3
`define CFRC_DELAY_MSB         2
`define CFRC_DELAY_LSB         0
`define CFRC_RESP_DISABLE      2'h2
`define CFRC_RETRY_NONE        3'h0
`define CFRC_UNIT_MS           35
`define CFRC_CLK_KHZ           50000
`define CFRC_UNIT_CYCLES       (`CFRC_UNIT_MS * `CFRC_CLK_KHZ)
`define CFRC_RETRY_PULSE       16
`endif
